//--- logic/tsi_consts.vh
/*
 * Constants for the transmit serializer interrupt flag block: register
 * offsets, flag bit positions and reset values.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef TSI_CONSTS_VH
`define TSI_CONSTS_VH

// Register offsets on the internal register port
`define TSI_ADDR_ENABLES    8'h0D
`define TSI_ADDR_FLAGS      8'h0E
`define TSI_ADDR_TX_DATA    8'h0F

// Flag and enable bit positions
`define TSI_BIT_UNDERFLOW   3
`define TSI_BIT_OVERFLOW    2
`define TSI_BIT_DONE        1
`define TSI_BIT_EMPTY       0

// Reset values
`define TSI_RST_FLAGS       4'h0
`define TSI_RST_ENABLES     4'h0
`define TSI_RST_RDATA       8'h00

// Reserved upper bits of the flag and enable registers
`define TSI_RSVD_BITS       4'h0

`endif

//--- logic/tsi_flag_cell.v
/*
 * One sticky interrupt flag: set by a hardware event, cleared by a
 * software clear strobe or by leaving transmit mode.
 * Assumes set, clear and mode come from logic on the same clock.
 */
`timescale 1ns/1ps

module tsi_flag_cell (
    input  wire clk,
    input  wire rstn,
    input  wire set_evt,
    input  wire clr_evt,
    input  wire tx_mode,
    output reg  flag
);

    // Set wins over a clear in the same cycle; outside transmit mode held at zero
    always @(posedge clk) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else if (!tx_mode) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (clr_evt) begin
            flag <= 1'b0;
        end
    end

endmodule // tsi_flag_cell

//--- logic/tsi_irq_flags.v
/*
 * Interrupt flags and enables of the transmit serializer: underflow,
 * overflow, done and empty, a read-only status register, an enable
 * register and a registered interrupt request.
 * Assumes a register port already decoded from the serial interface,
 * with one-cycle read and write strobes, and serializer event pulses
 * on the same clock. Transmit and receive enables come from the
 * control register held elsewhere.
 *
 * Behaviour in brief:
 *  - Underflow, overflow and done are sticky. A read of the status
 *    offset clears them, but an event in the same cycle wins.
 *  - Empty is a live level taken from the holding register occupancy,
 *    so reading the status never clears it. A data write does.
 *  - Leaving transmit mode clears every flag, the occupancy and the
 *    started marker, so the status reads zero from the second cycle outside transmit mode.
 *  - The enables only gate the request. Polling works with all of
 *    them cleared.
 *  - Request and read data leave straight from flip-flops, so the
 *    request lags the flag by one clock.
 */
`timescale 1ns/1ps
`include "tsi_consts.vh"

module tsi_irq_flags (
    input  wire       clk,
    input  wire       rstn,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       tx_enable,
    input  wire       rx_enable,
    input  wire       shifter_load,
    input  wire       bit_request,
    input  wire       bit_sent,
    input  wire       byte_done,
    output reg        irq
);

    reg  [3:0] enables;
    reg        data_held;
    reg        tx_started;
    wire       tx_mode;
    wire       wr_data;
    wire       wr_enables;
    wire       rd_flags;
    wire       set_underflow;
    wire       set_overflow;
    wire       set_done;
    wire       flag_underflow;
    wire       flag_overflow;
    wire       flag_done;
    wire       empty_flag;
    wire [3:0] flags;
    wire [7:0] status_byte;
    reg  [7:0] next_rdata;
    reg  [3:0] next_enables;
    reg        next_data_held;
    reg        next_tx_started;
    reg        next_irq;
    wire [3:0] pending;

    // Transmit mode: transmitter on and receiver off
    assign tx_mode    = tx_enable & ~rx_enable;

    // Register port decode
    assign wr_data    = reg_wr & (reg_addr == `TSI_ADDR_TX_DATA);
    assign wr_enables = reg_wr & (reg_addr == `TSI_ADDR_ENABLES);
    assign rd_flags   = reg_rd & (reg_addr == `TSI_ADDR_FLAGS);

    // Next enable value: only a write to the enable offset changes it. Writes to
    // the status offset decode to nothing here, so the flags stay untouched
    always @* begin
        next_enables = enables;
        if (wr_enables) begin
            next_enables = reg_wdata[3:0];
        end
    end

    // Enable register; upper data bits are dropped and read back as zero
    always @(posedge clk) begin
        if (!rstn) begin
            enables <= `TSI_RST_ENABLES;
        end else begin
            enables <= next_enables;
        end
    end

    // Next occupancy of the holding register. A write fills it and a shifter load
    // frees it. When both fall in one cycle the new byte is the one left waiting,
    // so the write wins. Leaving transmit mode drops whatever was waiting.
    always @* begin
        next_data_held = data_held;
        if (!tx_mode) begin
            next_data_held = 1'b0;
        end else if (wr_data) begin
            next_data_held = 1'b1;
        end else if (shifter_load) begin
            next_data_held = 1'b0;
        end
    end

    // Holding register occupancy flip-flop
    always @(posedge clk) begin
        if (!rstn) begin
            data_held <= 1'b0;
        end else begin
            data_held <= next_data_held;
        end
    end

    // Transmission has begun once the first bit has gone out. Underflow and done
    // are both held back until then, so an idle serializer that keeps asking for
    // bits before anything was sent raises nothing.
    always @* begin
        next_tx_started = tx_started;
        if (!tx_mode) begin
            next_tx_started = 1'b0;
        end else if (bit_sent) begin
            next_tx_started = 1'b1;
        end
    end

    // Started marker flip-flop
    always @(posedge clk) begin
        if (!rstn) begin
            tx_started <= 1'b0;
        end else begin
            tx_started <= next_tx_started;
        end
    end

    // Event conditions. A shifter load in the same cycle as a data write frees the
    // holding register first, so that write is no overflow. Done waits for the
    // holding register to be empty and for no byte to arrive in the same cycle.
    assign set_underflow = bit_request & ~data_held & tx_started;
    assign set_overflow  = wr_data & data_held & ~shifter_load;
    assign set_done      = byte_done & ~data_held & ~wr_data
                           & (tx_started | bit_sent);

    // Sticky flags, cleared by a read of the status register. Each cell lets its
    // set event win over a read in the same cycle, so no event is lost to a poll.
    tsi_flag_cell u_underflow (
        .clk     (clk),
        .rstn    (rstn),
        .set_evt (set_underflow),
        .clr_evt (rd_flags),
        .tx_mode (tx_mode),
        .flag    (flag_underflow)
    );

    tsi_flag_cell u_overflow (
        .clk     (clk),
        .rstn    (rstn),
        .set_evt (set_overflow),
        .clr_evt (rd_flags),
        .tx_mode (tx_mode),
        .flag    (flag_overflow)
    );

    tsi_flag_cell u_done (
        .clk     (clk),
        .rstn    (rstn),
        .set_evt (set_done),
        .clr_evt (rd_flags),
        .tx_mode (tx_mode),
        .flag    (flag_done)
    );

    // Empty follows occupancy; a data write fills it and so clears the flag
    assign empty_flag = tx_mode & ~data_held;

    // Flags are reported whatever the enables hold. Each sits at its fixed bit
    // position, so the enables line up with the same positions
    assign flags[`TSI_BIT_UNDERFLOW] = flag_underflow;
    assign flags[`TSI_BIT_OVERFLOW]  = flag_overflow;
    assign flags[`TSI_BIT_DONE]      = flag_done;
    assign flags[`TSI_BIT_EMPTY]     = empty_flag;
    assign status_byte = {`TSI_RSVD_BITS, flags};

    // Read data mux; unmapped offsets read zero
    always @* begin
        next_rdata = `TSI_RST_RDATA;
        case (reg_addr)
            `TSI_ADDR_FLAGS:   next_rdata = status_byte;
            `TSI_ADDR_ENABLES: next_rdata = {`TSI_RSVD_BITS, enables};
            default:           next_rdata = `TSI_RST_RDATA;
        endcase
    end

    // Read data registered on the read strobe and held until the next one
    always @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= `TSI_RST_RDATA;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // Pending conditions: a flag counts only where its enable bit is set
    assign pending = flags & enables;

    // Next request level; a cleared enable blocks its flag but not the status bit
    always @* begin
        next_irq = |pending;
    end

    // Request flip-flop. The request lags the flag by one clock, so a read that
    // clears the last flag drops the request one clock after the read edge
    always @(posedge clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

endmodule // tsi_irq_flags

//--- tb/tb_top.sv
/* Bench: host register calls and serializer event pulses.
   Assumes the checker is bound to the design. */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: %h not %h", $time, a, e); end end
module tb_top;
    reg        clk, rstn, tx_enable, rx_enable;
    reg  [3:0] ev; // Load, bit wanted, bit out, byte finished
    wire [7:0] a, d, rdata;
    wire       w, r, irq;
    int        num_errors = 0;
    int        total_checks = 0;
    tsi_host u_host (.clk(clk), .addr(a), .wdata(d), .wr(w), .rd(r));
    tsi_irq_flags u_tsi_irq_flags (.clk(clk), .rstn(rstn), .reg_addr(a), .reg_wdata(d),
        .reg_wr(w), .reg_rd(r), .reg_rdata(rdata), .tx_enable(tx_enable), .irq(irq),
        .rx_enable(rx_enable), .shifter_load(ev[3]), .bit_request(ev[2]),
        .bit_sent(ev[1]), .byte_done(ev[0]));
    // Verdict
    task end_of_test;
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Read, then compare data and request
    task rc(input [7:0] ad, input [7:0] e, input i);
        ev = 4'h0;
        u_host.op(1'b0, 1'b1, ad, 8'h00);
        `CHK(rdata, e)
        `CHK(irq, i)
    endtask
    // Idle cycle carrying serializer events
    task ic(input [3:0] e);
        ev = e;
        u_host.op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Watchdog
    initial begin
        #10000;
        num_errors++;
        end_of_test;
    end
    // Main sequence
    initial begin
        {rstn, tx_enable, rx_enable, ev} = 7'h0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        rc(8'h0E, 8'h00, 1'b0);
        tx_enable = 1'b1;
        ic(4'h0);
        rc(8'h0E, 8'h01, 1'b0);
        u_host.op(1'b1, 1'b0, 8'h0D, 8'hF4);
        rc(8'h0D, 8'h04, 1'b0);
        u_host.op(1'b1, 1'b0, 8'h0F, 8'h12);
        rc(8'h0E, 8'h00, 1'b0);
        u_host.op(1'b1, 1'b0, 8'h0F, 8'h12);
        u_host.op(1'b1, 1'b0, 8'h0F, 8'h34);
        rc(8'h0E, 8'h04, 1'b1);
        u_host.op(1'b1, 1'b0, 8'h0D, 8'h00);
        ic(4'hA);
        ic(4'h4);
        rc(8'h0E, 8'h09, 1'b0);
        ic(4'h1);
        rc(8'h0E, 8'h03, 1'b0);
        rc(8'h0E, 8'h01, 1'b0);
        u_host.op(1'b1, 1'b0, 8'h0E, 8'hFF);
        rc(8'h0E, 8'h01, 1'b0);
        rc(8'h55, 8'h00, 1'b0);
        u_host.op(1'b1, 1'b0, 8'h0D, 8'h01);
        rc(8'h0E, 8'h01, 1'b1);
        ev = 4'h4;
        u_host.op(1'b0, 1'b1, 8'h0E, 8'h00);
        rc(8'h0E, 8'h09, 1'b1);
        rx_enable = 1'b1;
        ic(4'h0);
        rc(8'h0E, 8'h00, 1'b0);
        ic(4'h0);
        end_of_test;
    end
endmodule // tb_top

//--- tb/tsi_host.sv
/* Host model driving the register port strobes.
   Assumes each call starts at a falling clock edge. */
`timescale 1ns/1ps
module tsi_host (
    input  wire       clk,
    output reg  [7:0] addr,
    output reg  [7:0] wdata,
    output reg        wr,
    output reg        rd
);
    // One access a cycle; idle data lines show the inverse of the last value
    task op(input w, input r, input [7:0] a, input [7:0] d);
        {wr, rd, addr} = {w, r, a};
        wdata = w ? d : ~wdata;
        @(negedge clk);
    endtask
    // Idle port at start
    initial {wr, rd, addr, wdata} = 18'h0;
endmodule // tsi_host

//--- tb/tsi_irq_flags_sva.sv
/* Port assertions for the transmit flag block.
   Assumes one clock, synchronous reset, bound to the design top. */
`timescale 1ns/1ps
module tsi_irq_flags_sva (
    input wire       clk, rstn, reg_wr, reg_rd, tx_enable, rx_enable,
    input wire       shifter_load, bit_request, bit_sent, byte_done, irq,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata
);
    // Decoded mode, status read, data write and quiet cycle
    wire tx = tx_enable & ~rx_enable;
    wire rs = reg_rd & (reg_addr == 8'h0E);
    wire wd = reg_wr & (reg_addr == 8'h0F);
    wire qt = ~bit_request & ~byte_done & ~reg_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_OFF_READ: assert property (rs && !tx && !$past(tx) |=> reg_rdata == 8'h00)
        else $error("flags outside tx");
    AST_EMPTY: assert property (wd && tx && !shifter_load ##1 rs && tx |=> !reg_rdata[0])
        else $error("empty kept");
    AST_RD_CLR: assert property (rs && qt ##1 rs && qt |=> reg_rdata[3:1] == 3'h0)
        else $error("read kept flags");
    AST_RSVD: assert property (reg_rdata[7:4] == 4'h0)
        else $error("reserved set");
    AST_UNDER: assert property (tx && shifter_load && bit_sent && !reg_wr ##1
        tx && bit_request && !reg_wr ##1 rs && tx |=> reg_rdata[3])
        else $error("no underflow");
    AST_OVER: assert property (wd && tx ##1 wd && tx && !shifter_load ##1
        rs && tx |=> reg_rdata[2])
        else $error("no overflow");
    AST_EN_OFF: assert property (reg_wr && reg_addr == 8'h0D &&
        reg_wdata[3:0] == 4'h0 |=> ##1 !irq)
        else $error("masked request");
    AST_OFF_IRQ: assert property (!tx [*2] |=> !irq)
        else $error("request outside tx");
endmodule // tsi_irq_flags_sva
bind tsi_irq_flags tsi_irq_flags_sva u_sva (.*);
